// ---- shared/ultp_pkg.sv ----
/*
 * Package for the user logic test pattern block: register indices, field positions,
 * reset values and data path geometry.
 * Assumes a single data clock domain and a host register port of word indices.
 */
package ultp_pkg;
    localparam int ULTP_NUM_CH = 2;
    localparam int ULTP_PAR = 8;
    localparam int ULTP_SW = 16;
    localparam int ULTP_WORD_W = ULTP_PAR * ULTP_SW;
    localparam int ULTP_ADDR_W = 2;
    localparam int ULTP_REC_LEN_W = 16;
    localparam logic [ULTP_ADDR_W-1:0] ULTP_IDX_IDENT = 2'h0;
    localparam logic [ULTP_ADDR_W-1:0] ULTP_IDX_CONTROL = 2'h1;
    localparam logic [ULTP_ADDR_W-1:0] ULTP_IDX_ORIGIN = 2'h2;
    localparam logic [ULTP_ADDR_W-1:0] ULTP_IDX_RECLEN = 2'h3;
    localparam int ULTP_CTRL_PATTERN_EN_BIT = 31;
    localparam logic [31:0] ULTP_CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] ULTP_ORIGIN_RESET = 32'h0000_0000;
    localparam logic [31:0] ULTP_RECLEN_RESET = 32'h0000_0000;
    localparam logic [31:0] ULTP_UNMAPPED_READ = 32'h0000_0000;
    // Arbitrary identification values, chosen locally
    localparam logic [31:0] ULTP_AREA1_IDENT = 32'h5a17_0001;
    localparam logic [31:0] ULTP_AREA2_IDENT = 32'h5a17_0002;
    localparam int ULTP_BUF_DEPTH = 2;

    typedef enum logic [2:0] {
        ULTP_REC_IDLE = 3'b001,
        ULTP_REC_OPEN = 3'b010,
        ULTP_REC_ENDLESS = 3'b100
    } ultp_rec_state_t;
endpackage : ultp_pkg

// ---- shared/ultp_stream_if.sv ----
/*
 * Stream carrier between the framing logic and the output buffer.
 * Assumes both ends share the data clock.
 */
`timescale 1ns/1ps
interface ultp_stream_if;
    import ultp_pkg::*;
    logic valid;
    logic ready;
    logic [ULTP_NUM_CH*ULTP_WORD_W-1:0] data;
    logic rec_start;
    logic rec_stop;
    modport src (output valid, output data, output rec_start, output rec_stop, input ready);
    modport snk (input valid, input data, input rec_start, input rec_stop, output ready);
endinterface : ultp_stream_if

// ---- src/ultp_area2.sv ----
/*
 * Second user logic area: per-word register ports, ramp test pattern, data thinning
 * and record framing with a two-entry output buffer.
 * Assumes the host register bus slave outside completes every bus transaction and
 * uses the port pairs below; all inputs are on the data clock.
 */
`timescale 1ns/1ps
// Overview of operation
// - Identification word at index 0 is read-only and constant; writes ignored.
// - Control bit 31 enables the pattern; zero passes data through unchanged.
// - Pattern ramps from origin by one per sample, restarting each cycle.
// - Origin is 32 bits; low sample-width bits used as two's complement.
// - Every read/write register has its own read port and write port; identification has a read port only.
// - Access type follows wiring: loopback, read-only or write-only.
// - Every access completes, mapped or not, so the host never hangs.
// - Output valid may be dropped on chosen cycles to thin data.
// - Records on a channel all share one length, or one endless record.
// - Endless record: start with valid once, never a stop afterwards.
// - Framing outputs stay consistent with the valid they accompany.
// - Start or stop counts only in a cycle with valid asserted.
// - Start and stop never share a cycle; shortest record is two cycles.
// - Exactly one stop per fixed-length start; records dropped only as pairs.
module ultp_area2
    import ultp_pkg::*;
(
    input wire logic clock, // Data clock, 125 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic reg_wr_en, // Host write strobe
    input wire logic [ULTP_ADDR_W-1:0] reg_wr_idx, // Host write word index
    input wire logic [31:0] reg_wr_data, // Host write data
    input wire logic [3:0] reg_wr_strb, // Host byte enables
    input wire logic reg_rd_en, // Host read strobe
    input wire logic [ULTP_ADDR_W-1:0] reg_rd_idx, // Host read word index
    output logic [31:0] reg_rd_data, // Read data, valid with ack
    output logic reg_rd_ack, // Read answered
    output logic reg_wr_ack, // Write answered
    input wire logic acq_active, // Acquisition running
    input wire logic [ULTP_NUM_CH*ULTP_WORD_W-1:0] in_data, // Incoming channel words
    input wire logic in_valid, // Incoming valid
    input wire logic [ULTP_NUM_CH-1:0] thin_mask, // Drop the beat taken this cycle from the output
    output logic out_valid, // Outgoing valid
    input wire logic out_ready, // Downstream accepts
    output logic [ULTP_NUM_CH*ULTP_WORD_W-1:0] out_data, // Outgoing words
    output logic out_rec_start, // Record start, with valid
    output logic out_rec_stop, // Record stop, with valid
    output logic in_ready // Upstream may send
);
    ultp_stream_if st ();

    // Write ports toward logic and read ports toward host, one pair per read/write word
    logic [31:0] control_wport, control_rport, next_control_wport;
    logic [31:0] origin_wport, origin_rport, next_origin_wport;
    logic [31:0] reclen_wport, reclen_rport, next_reclen_wport;
    logic [31:0] ident_rport;
    logic [31:0] next_rd_data;
    logic next_rd_ack, next_wr_ack;
    logic pattern_enable;
    logic [31:0] ramp_origin;
    logic [ULTP_NUM_CH*ULTP_WORD_W-1:0] gen_data;
    logic gen_valid, next_gen_valid;
    logic [ULTP_REC_LEN_W-1:0] beat_cnt, next_beat_cnt;
    ultp_rec_state_t rec_state, next_rec_state;
    logic [ULTP_REC_LEN_W-1:0] rec_len;
    logic [ULTP_REC_LEN_W-1:0] rec_len_held, next_rec_len_held;
    logic frame_start, frame_stop;

    // Apply byte enables to a stored word
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                                input logic [31:0] new_w,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    ////////////////////////////////////////////////////////////////////////////
    // Register access wiring: loopback for read/write, constant for read-only
    assign ident_rport = ULTP_AREA2_IDENT;
    assign control_rport = control_wport;
    assign origin_rport = origin_wport;
    assign reclen_rport = reclen_wport;
    assign pattern_enable = control_wport[ULTP_CTRL_PATTERN_EN_BIT];
    assign ramp_origin = origin_wport;
    assign rec_len = reclen_wport[ULTP_REC_LEN_W-1:0];

    // Write side; byte merge reads back the stored word
    always_comb begin
        next_control_wport = control_wport;
        next_origin_wport = origin_wport;
        next_reclen_wport = reclen_wport;
        next_wr_ack = reg_wr_en;
        if (reg_wr_en) begin
            case (reg_wr_idx)
                ULTP_IDX_CONTROL: begin
                    next_control_wport = merge_bytes(control_rport, reg_wr_data, reg_wr_strb);
                end
                ULTP_IDX_ORIGIN: begin
                    next_origin_wport = merge_bytes(origin_rport, reg_wr_data, reg_wr_strb);
                end
                ULTP_IDX_RECLEN: begin
                    next_reclen_wport = merge_bytes(reclen_rport, reg_wr_data, reg_wr_strb);
                end
                default: begin
                    next_control_wport = control_wport;
                end
            endcase
        end
    end

    // Read side; every read gets one ack, unmapped reads zero
    always_comb begin
        next_rd_ack = reg_rd_en;
        next_rd_data = reg_rd_data;
        if (reg_rd_en) begin
            case (reg_rd_idx)
                ULTP_IDX_IDENT: next_rd_data = ident_rport;
                ULTP_IDX_CONTROL: next_rd_data = control_rport;
                ULTP_IDX_ORIGIN: next_rd_data = origin_rport;
                ULTP_IDX_RECLEN: next_rd_data = reclen_rport;
                default: next_rd_data = ULTP_UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            control_wport <= ULTP_CONTROL_RESET;
            origin_wport <= ULTP_ORIGIN_RESET;
            reclen_wport <= ULTP_RECLEN_RESET;
            reg_rd_data <= 32'h0000_0000;
            reg_rd_ack <= 1'b0;
            reg_wr_ack <= 1'b0;
        end else begin
            control_wport <= next_control_wport;
            origin_wport <= next_origin_wport;
            reclen_wport <= next_reclen_wport;
            reg_rd_data <= next_rd_data;
            reg_rd_ack <= next_rd_ack;
            reg_wr_ack <= next_wr_ack;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pattern per channel; only sample-width low bits of origin are taken
    for (genvar c = 0; c < ULTP_NUM_CH; c++) begin : g_ramp
        ultp_ramp_gen u_ramp (
            .clock(clock),
            .rst(rst),
            .origin(ramp_origin[ULTP_SW-1:0]),
            .enable(pattern_enable),
            .data_in(in_data[c*ULTP_WORD_W +: ULTP_WORD_W]),
            .data_out(gen_data[c*ULTP_WORD_W +: ULTP_WORD_W])
        );
    end

    // Valid is registered in step with the data; thin mask drops beats
    always_comb begin
        next_gen_valid = in_valid && in_ready && (thin_mask == '0);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            gen_valid <= 1'b0;
        end else begin
            gen_valid <= next_gen_valid;
        end
    end

    // Upstream stalls unless a free entry remains both for the beat now in the
    // pattern register and for one taken at this edge. Judging only from the
    // buffer's own flags and gen_valid keeps out_ready off this path, at some throughput.
    assign in_ready = !out_valid || (st.ready && !gen_valid);

    ////////////////////////////////////////////////////////////////////////////
    // Record framing: fixed length (rec_len beats) or one endless record if zero.
    // Framing is only raised on beats that carry valid, so each pulse overlaps
    // valid in exactly one cycle. A length of one is raised to two, since start
    // and stop cannot share a beat. The length is captured at the start, so a
    // host write in mid-record cannot give one record a different length.
    always_comb begin
        next_rec_state = rec_state;
        next_beat_cnt = beat_cnt;
        next_rec_len_held = rec_len_held;
        frame_start = 1'b0;
        frame_stop = 1'b0;
        case (rec_state)
            ULTP_REC_IDLE: begin
                if (gen_valid && acq_active) begin
                    frame_start = 1'b1;
                    next_beat_cnt = ULTP_REC_LEN_W'(1);
                    next_rec_len_held = rec_len;
                    next_rec_state = (rec_len == '0) ? ULTP_REC_ENDLESS : ULTP_REC_OPEN;
                end
            end
            ULTP_REC_OPEN: begin
                if (gen_valid) begin
                    next_beat_cnt = beat_cnt + ULTP_REC_LEN_W'(1);
                    if (next_beat_cnt >= rec_len_held) begin
                        frame_stop = 1'b1;
                        next_rec_state = ULTP_REC_IDLE;
                    end
                end
            end
            ULTP_REC_ENDLESS: begin
                next_rec_state = ULTP_REC_ENDLESS;
            end
            default: begin
                next_rec_state = ULTP_REC_IDLE;
            end
        endcase
        if (!acq_active && rec_state == ULTP_REC_ENDLESS) begin
            next_rec_state = ULTP_REC_IDLE;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rec_state <= ULTP_REC_IDLE;
            beat_cnt <= '0;
            rec_len_held <= '0;
        end else begin
            rec_state <= next_rec_state;
            beat_cnt <= next_beat_cnt;
            rec_len_held <= next_rec_len_held;
        end
    end

    // Framing rides in the same buffer entry as its valid beat
    assign st.valid = gen_valid;
    assign st.data = gen_data;
    assign st.rec_start = frame_start;
    assign st.rec_stop = frame_stop;

    ////////////////////////////////////////////////////////////////////////////
    // Output buffer; a downstream stall holds words rather than dropping them
    ultp_skid_buf u_buf (
        .clock(clock),
        .rst(rst),
        .in_s(st),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_data),
        .out_start(out_rec_start),
        .out_stop(out_rec_stop)
    );
endmodule : ultp_area2

// ---- src/ultp_ramp_gen.sv ----
/*
 * Ramp test pattern for one channel word: origin, origin+1, ... per sample.
 * Assumes origin is the low sample-width bits of the origin register.
 */
`timescale 1ns/1ps
module ultp_ramp_gen
    import ultp_pkg::*;
(
    input wire logic clock, // Data clock
    input wire logic rst, // Synchronous reset
    input wire logic [ULTP_SW-1:0] origin, // Two's complement start value
    input wire logic enable, // Pattern replaces data
    input wire logic [ULTP_WORD_W-1:0] data_in, // Incoming channel word
    output logic [ULTP_WORD_W-1:0] data_out // Registered channel word
);
    logic [ULTP_WORD_W-1:0] next_data_out;

    ////////////////////////////////////////////////////////////////////////////
    // Ramp restarts each cycle; wraps modulo sample width like signed adds
    always_comb begin
        next_data_out = data_in;
        if (enable) begin
            for (int i = 0; i < ULTP_PAR; i++) begin
                next_data_out[i*ULTP_SW +: ULTP_SW] = origin + ULTP_SW'(i);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            data_out <= '0;
        end else begin
            data_out <= next_data_out;
        end
    end
endmodule : ultp_ramp_gen

// ---- src/ultp_skid_buf.sv ----
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes the source holds nothing back that it cannot re-offer after ready falls.
 */
`timescale 1ns/1ps
module ultp_skid_buf
    import ultp_pkg::*;
(
    input wire logic clock, // Data clock
    input wire logic rst, // Synchronous reset
    ultp_stream_if.snk in_s, // Filling side
    output logic out_valid, // Word available
    input wire logic out_ready, // Drain accepts
    output logic [ULTP_NUM_CH*ULTP_WORD_W-1:0] out_data, // Word
    output logic out_start, // Record start with word
    output logic out_stop // Record stop with word
);
    localparam int EW = ULTP_NUM_CH*ULTP_WORD_W + 2;
    logic [EW-1:0] mem [ULTP_BUF_DEPTH];
    logic [EW-1:0] next_mem [ULTP_BUF_DEPTH];
    logic rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
    logic [1:0] count, next_count;
    logic push, pop;
    logic head_start, head_stop;

    ////////////////////////////////////////////////////////////////////////////
    // Honest full/empty; framing travels in the same entry as its data
    assign in_s.ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign {head_start, head_stop, out_data} = mem[rd_ptr];
    // An emptied slot keeps its old framing bits; they must never reach the pins
    assign out_start = head_start && out_valid;
    assign out_stop = head_stop && out_valid;
    assign push = in_s.valid && in_s.ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_mem = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (push) begin
            next_mem[wr_ptr] = {in_s.rec_start, in_s.rec_stop, in_s.data};
            next_wr_ptr = ~wr_ptr;
        end
        if (pop) begin
            next_rd_ptr = ~rd_ptr;
        end
        next_count = count + 2'(push) - 2'(pop);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mem[0] <= '0;
            mem[1] <= '0;
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            mem <= next_mem;
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            count <= next_count;
        end
    end
endmodule : ultp_skid_buf

// ---- tb/ultp_area2_assertions.sv ----
/*
 * Port checker for ultp_area2: register answers, framing and output hold.
 * Assumes one data clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module ultp_area2_assertions
    import ultp_pkg::*;
(
    input wire logic clock, // Data clock
    input wire logic rst, // Sync reset
    input wire logic reg_wr_en, // Write strobe
    input wire logic reg_rd_en, // Read strobe
    input wire logic [ULTP_ADDR_W-1:0] reg_rd_idx, // Read index
    input wire logic [31:0] reg_rd_data, // Read data
    input wire logic reg_rd_ack, // Read answer
    input wire logic reg_wr_ack, // Write answer
    input wire logic out_valid, // Output valid
    input wire logic out_ready, // Output accept
    input wire logic [ULTP_NUM_CH*ULTP_WORD_W-1:0] out_data, // Output words
    input wire logic out_rec_start, // Record start
    input wire logic out_rec_stop // Record stop
);
    default clocking dck @(posedge clock);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////
    // Open record tracker; an endless record simply stays open
    logic rec_open;
    logic next_rec_open;
    always_comb begin
        next_rec_open = rec_open;
        if (out_valid && out_ready && out_rec_stop) begin
            next_rec_open = 1'b0;
        end else if (out_valid && out_ready && out_rec_start) begin
            next_rec_open = 1'b1;
        end
    end
    always_ff @(posedge clock) begin
        rec_open <= rst ? 1'b0 : next_rec_open;
    end
    ////////////////////////////////////////////////
    // Stall then hold: a refused beat must not change under the receiver
    sequence s_stall;
        out_valid && !out_ready;
    endsequence
    sequence s_held;
        out_valid && $stable(out_data) && $stable(out_rec_start) && $stable(out_rec_stop);
    endsequence
    a_wr_ack_due: assert property (reg_wr_en |=> reg_wr_ack)
        else $error("write not acknowledged");
    a_wr_ack_cause: assert property (reg_wr_ack |-> $past(reg_wr_en))
        else $error("write ack without request");
    a_rd_ack_due: assert property (reg_rd_en |=> reg_rd_ack)
        else $error("read not acknowledged");
    a_ident_fixed: assert property (reg_rd_en && reg_rd_idx == ULTP_IDX_IDENT |=>
        reg_rd_data == ULTP_AREA2_IDENT) else $error("identification word wrong");
    a_rd_data_hold: assert property (!reg_rd_ack |-> $stable(reg_rd_data))
        else $error("read data moved without ack");
    a_frame_valid: assert property ((out_rec_start || out_rec_stop) |-> out_valid)
        else $error("framing without valid");
    a_start_stop_apart: assert property (!(out_rec_start && out_rec_stop))
        else $error("start and stop together");
    a_beat_held: assert property (s_stall |=> s_held)
        else $error("stalled beat changed");
    a_stop_opened: assert property (out_valid && out_ready && out_rec_stop |-> rec_open)
        else $error("stop without open record");
endmodule : ultp_area2_assertions

bind ultp_area2 ultp_area2_assertions ultp_area2_assertions_i (.clock(clock), .rst(rst),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_idx(reg_rd_idx),
    .reg_rd_data(reg_rd_data), .reg_rd_ack(reg_rd_ack), .reg_wr_ack(reg_wr_ack),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .out_rec_start(out_rec_start), .out_rec_stop(out_rec_stop));

// ---- tb/ultp_area2_bench.sv ----
/*
 * Self-checking bench for ultp_area2 with a queue model of the data path.
 * Assumes the drain model downstream and a host driving the port pairs.
 */
`timescale 1ns/1ps
module ultp_area2_bench import ultp_pkg::*;;
    localparam int W = ULTP_NUM_CH * ULTP_WORD_W;
    logic clock = 0, rst = 1, reg_wr_en = 0, reg_rd_en = 0, acq_active = 0, in_valid = 0;
    logic [1:0] reg_wr_idx = 0, reg_rd_idx = 0, thin_mask = 0, mode = 0;
    logic [31:0] reg_wr_data = 0, reg_rd_data;
    logic [3:0] reg_wr_strb = 0;
    logic [W-1:0] in_data = 0, out_data;
    logic reg_rd_ack, reg_wr_ack, out_valid, out_ready, out_rec_start, out_rec_stop, in_ready;
    logic [W-1:0] exp_q[$];
    logic [1:0] fr_q[$];
    logic [31:0] mirror[4] = '{ULTP_AREA2_IDENT, 32'h0, 32'h0, 32'h0};
    int err_count = 0, compares = 0, k = 0, n = 0;
    bit opened = 0;
    ultp_area2 ultp_area2_i (.clock(clock), .rst(rst), .reg_wr_en(reg_wr_en),
        .reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data), .reg_wr_strb(reg_wr_strb),
        .reg_rd_en(reg_rd_en), .reg_rd_idx(reg_rd_idx), .reg_rd_data(reg_rd_data),
        .reg_rd_ack(reg_rd_ack), .reg_wr_ack(reg_wr_ack), .acq_active(acq_active),
        .in_data(in_data), .in_valid(in_valid), .thin_mask(thin_mask),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
        .out_rec_start(out_rec_start), .out_rec_stop(out_rec_stop), .in_ready(in_ready));
    ultp_drain_model ultp_drain_model_i (.clock(clock), .rst(rst), .mode(mode),
        .out_ready(out_ready));
    always #4 clock = ~clock;
    ////////////////////////////////////////////////
    task check(input string what, input logic [W-1:0] seen, input logic [W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task wrap_up;
        $display("err_count=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    function automatic logic [W-1:0] rnd();
        for (int i = 0; i < W / 32; i++) rnd[32*i+:32] = $urandom;
    endfunction : rnd
    // Host side; masked writes go only to read/write words
    task reg_wr(input logic [1:0] idx, input logic [31:0] d, input logic [3:0] s);
        @(posedge clock);
        reg_wr_en <= 1;
        reg_wr_idx <= idx;
        reg_wr_data <= d;
        reg_wr_strb <= s;
        @(posedge clock);
        reg_wr_en <= 0;
        @(negedge clock);
        check("wr_ack", reg_wr_ack, 1);
        for (int b = 0; b < 4; b++) if (idx != 0 && s[b]) mirror[idx][8*b+:8] = d[8*b+:8];
    endtask : reg_wr
    task reg_rd(input logic [1:0] idx);
        @(posedge clock);
        reg_rd_en <= 1;
        reg_rd_idx <= idx;
        @(posedge clock);
        reg_rd_en <= 0;
        @(negedge clock);
        check("rd_ack", reg_rd_ack, 1);
        check("rd_data", reg_rd_data, mirror[idx]);
    endtask : reg_rd
    // Offers one beat and leaves valid up, so the next call follows back to back
    task send(input logic [W-1:0] d, input logic [1:0] th);
        int i, len;
        logic [W-1:0] e;
        logic st, sp;
        @(posedge clock);
        in_valid <= 1;
        in_data <= d;
        thin_mask <= th;
        i = 0;
        @(negedge clock);
        while (in_ready !== 1 && i < 60) begin
            @(negedge clock);
            i++;
        end
        check("in_ready", in_ready, 1);
        e = d;
        len = mirror[3][15:0] < 2 ? 2 : mirror[3][15:0];
        if (mirror[1][31]) for (int c = 0; c < ULTP_NUM_CH; c++)
            for (int s = 0; s < ULTP_PAR; s++)
                e[c*ULTP_WORD_W+s*ULTP_SW+:ULTP_SW] = mirror[2][15:0] + 16'(s);
        st = 0;
        sp = 0;
        if (th == 0 && acq_active && mirror[3] == 0) begin
            st = !opened;
            opened = 1;
        end else if (th == 0 && acq_active) begin
            st = k == 0;
            sp = k == len - 1;
            k = (k + 1) % len;
        end
        if (th == 0) exp_q.push_back(e);
        if (th == 0) fr_q.push_back({st, sp});
    endtask : send
    task drain;
        int i;
        @(posedge clock);
        in_valid <= 0;
        i = 0;
        while (exp_q.size() > 0 && i < 300) begin
            @(negedge clock);
            i++;
        end
        check("drained", exp_q.size(), 0);
    endtask : drain
    ////////////////////////////////////////////////
    // Output monitor: every accepted beat against the model
    always @(negedge clock) begin
        if (!rst && out_valid === 1 && out_ready === 1) begin
            if (exp_q.size() == 0) check("extra beat", 1, 0);
            else check("out_data", out_data, exp_q.pop_front());
            if (fr_q.size() > 0) begin
                check("frame", {out_rec_start, out_rec_stop}, fr_q.pop_front());
            end
        end
    end
    // Watchdog, far beyond the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        wrap_up;
    end
    ////////////////////////////////////////////////
    initial begin
        void'($urandom(27));
        repeat (6) @(posedge clock);
        rst <= 0;
        for (int r = 0; r < 4; r++) reg_rd(2'(r));
        reg_wr(0, $urandom, 4'hf);
        reg_rd(0);
        reg_wr(2, $urandom, 4'hf);
        reg_wr(2, 32'h0000_fffa, 4'h3);
        reg_rd(2);
        reg_wr(1, 32'h8000_0000, 4'h8);
        reg_rd(1);
        $display("test registers done");
        // Ramp wraps through zero from a negative origin
        for (int i = 0; i < 6; i++) send(rnd(), 0);
        drain;
        reg_wr(1, 32'h0, 4'hf);
        mode <= 1;
        for (int i = 0; i < 10; i++) send(rnd(), ($urandom % 3 == 0) ? 2'($urandom) : 2'h0);
        drain;
        $display("test pattern and thinning done");
        // Stalled receiver: buffer must refuse, then lose nothing
        mode <= 2;
        fork
            for (int i = 0; i < 6; i++) send(rnd(), 0);
        join_none
        repeat (12) @(negedge clock);
        check("buffer full", in_ready, 0);
        mode <= 1;
        wait fork;
        drain;
        $display("test buffer done");
        // Fixed-length records under thinning, ending on a record boundary
        reg_wr(3, 32'h3, 4'hf);
        k = 0;
        n = 0;
        @(posedge clock);
        acq_active <= 1;
        while (!(k == 0 && n >= 6) && n < 60) begin
            send(rnd(), ($urandom % 3 == 0) ? 2'h1 : 2'h0);
            n++;
        end
        drain;
        @(posedge clock);
        acq_active <= 0;
        // One endless record: a single start, never a stop
        reg_wr(3, 32'h0, 4'hf);
        opened = 0;
        @(posedge clock);
        acq_active <= 1;
        for (int i = 0; i < 6; i++) send(rnd(), ($urandom % 3 == 0) ? 2'h2 : 2'h0);
        drain;
        @(posedge clock);
        acq_active <= 0;
        $display("test records done");
        wrap_up;
    end
endmodule : ultp_area2_bench

// ---- tb/ultp_drain_model.sv ----
/*
 * Downstream data path model: accepts at once, at random, or not at all.
 * Assumes the data clock and the bench's fixed seed.
 */
`timescale 1ns/1ps
module ultp_drain_model (
    input wire logic clock, // Data clock
    input wire logic rst, // Sync reset
    input wire logic [1:0] mode, // 0 prompt, 1 random, 2 stalled
    output logic out_ready // Accept
);
    // Ready changes only just after an edge
    always @(posedge clock) begin
        out_ready <= rst ? 1'b1 : mode == 2'h0 ? 1'b1 : mode == 2'h1 ? 1'($urandom) : 1'b0;
    end
endmodule : ultp_drain_model
